// *** logic/arb_pkg.sv ***
// Purpose: shared constants for the prioritised interrupt arbiter
// Assumes: 16-bit register port, word index addressing
// Notes:   register indices are word indices on the plain port
package arb_pkg;
	localparam int          NUM_PRIO_REGS   = 8;
	localparam int          NUM_PINS        = 6;
	localparam int          NUM_PERIPH      = 32;
	localparam int          NUM_SRC         = NUM_PINS + NUM_PERIPH;
	localparam logic [3:0]  ADDR_PRIO_A     = 4'h0;
	localparam logic [3:0]  ADDR_CONTROL    = 4'h8;
	localparam logic [3:0]  ADDR_FLAGS      = 4'h9;
	localparam logic [15:0] PRIO_RESET      = 16'h0000;
	localparam logic [15:0] CONTROL_RESET   = 16'h0000;
	localparam logic [15:0] FLAGS_RESET     = 16'h0000;
	localparam int          NMI_LEVEL_BIT   = 15;
	localparam int          NMI_EDGE_BIT    = 8;
	localparam logic [15:0] SENSE_MASK      = 16'h00F3;
	localparam logic [15:0] CONTROL_WMASK   = 16'h01F3;
	localparam logic [4:0]  NMI_LEVEL       = 5'h10;
	localparam logic [3:0]  LEVEL_MASKED    = 4'h0;
	localparam logic [7:0]  VEC_NMI         = 8'h0B;
	localparam logic [7:0]  VEC_CONV_A      = 8'h88;
	localparam logic [7:0]  VEC_CONV_B      = 8'h8A;
	// bit position of each pin in the control and flag registers
	localparam int PIN_BIT [NUM_PINS] = '{7, 6, 5, 4, 1, 0};
	// vector number per pin
	localparam logic [7:0] PIN_VEC [NUM_PINS] =
		'{8'h40, 8'h41, 8'h42, 8'h43, 8'h46, 8'h47};
	// field index (register*4 + nibble from top) per pin
	localparam int PIN_FIELD [NUM_PINS] = '{0, 1, 2, 3, 6, 7};
	typedef enum logic [1:0] {IDLE, OFFER} offer_state_e;
endpackage : arb_pkg

// *** logic/level_sel_if.sv ***
// Purpose: carries a candidate level and vector between arbiter parts
// Assumes: single clock domain, combinational content
// Notes:   level 0 means no candidate
`timescale 1ns/100ps
interface level_sel_if;
	logic [4:0] level;
	logic [7:0] vector;
	logic [5:0] index;
	logic       is_nmi;
	modport pick (output level, output vector, output index, output is_nmi);
	modport use_it (input level, input vector, input index, input is_nmi);
endinterface : level_sel_if

// *** logic/level_picker.sv ***
// Purpose: picks the highest level among candidate sources
// Assumes: source 0 has the highest default order
// Notes:   >= compare in a descending loop keeps lower index on ties
`timescale 1ns/100ps
module level_picker #(
	parameter int N = arb_pkg::NUM_SRC
) (
	input  wire logic [N-1:0]   active,
	input  wire logic [4*N-1:0] levels,
	input  wire logic [8*N-1:0] vectors,
	input  wire logic           nmi_req,
	level_sel_if.pick           sel
);
	logic [4:0] best_level;
	logic [7:0] best_vec;
	logic [5:0] best_idx;

	always_comb begin
		best_level = 5'h00;
		best_vec   = 8'h00;
		best_idx   = 6'h00;
		// descending index so lower index overrides on equal level
		for (int i = N - 1; i >= 0; i--) begin
			if (active[i] && levels[4*i +: 4] != arb_pkg::LEVEL_MASKED
			    && {1'b0, levels[4*i +: 4]} >= best_level) begin
				best_level = {1'b0, levels[4*i +: 4]};
				best_vec   = vectors[8*i +: 8];
				best_idx   = 6'(i);
			end
		end
		if (nmi_req) begin
			best_level = arb_pkg::NMI_LEVEL;
			best_vec   = arb_pkg::VEC_NMI;
		end
	end

	assign sel.level  = best_level;
	assign sel.vector = best_vec;
	assign sel.index  = best_idx;
	assign sel.is_nmi = nmi_req;
endmodule : level_picker

// *** logic/prioritised_interrupt_controller.sv ***
// Purpose: prioritised interrupt arbiter with pin detect and flags
// Assumes: pins asynchronous, peripheral requests synchronous levels
// Notes:   register index on addr; reads answer one cycle later
`timescale 1ns/100ps
module prioritised_interrupt_controller #(
	parameter bit ALT_CONV_VECTOR = 1'b0
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [3:0]                    addr,
	input  wire logic [15:0]                   wdata,
	input  wire logic                          wr,
	input  wire logic                          rd,
	output logic      [15:0]                   rdata,
	input  wire logic                          nonmaskable_pin,
	input  wire logic [arb_pkg::NUM_PINS-1:0]  ext_request_pin_n,
	input  wire logic [arb_pkg::NUM_PERIPH-1:0] periph_req,
	input  wire logic [3:0]                    cpu_mask_level,
	output logic                               cpu_irq,
	output logic      [3:0]                    cpu_irq_level,
	output logic      [7:0]                    cpu_irq_vector,
	output logic                               cpu_irq_nmi,
	input  wire logic                          cpu_ack
);
	localparam int NP = arb_pkg::NUM_PINS;
	localparam int NS = arb_pkg::NUM_SRC;

	logic [15:0] prio_reg [arb_pkg::NUM_PRIO_REGS];
	logic [15:0] prio_next [arb_pkg::NUM_PRIO_REGS];
	logic [15:0] control_reg, control_next;
	logic [15:0] flags_reg, flags_next;
	logic [15:0] read_seen_reg, read_seen_next;
	logic [15:0] rdata_next;
	logic [2:0]  nmi_sync_reg, nmi_sync_next;
	logic        nmi_level_reg, nmi_level_next;
	logic        nmi_pend_reg, nmi_pend_next;
	logic [2:0]  pin_sync_reg [NP];
	logic [2:0]  pin_sync_next [NP];
	logic [NP-1:0] pin_low_reg, pin_low_next;
	arb_pkg::offer_state_e state_reg, state_next;
	logic [3:0]  held_level_reg, held_level_next;
	logic [7:0]  held_vec_reg, held_vec_next;
	logic [5:0]  held_idx_reg, held_idx_next;
	logic        held_nmi_reg, held_nmi_next;

	logic [NS-1:0]   active;
	logic [4*NS-1:0] levels;
	logic [8*NS-1:0] vectors;
	logic [NP-1:0]   pin_fall;
	logic [NP-1:0]   pin_flag;
	logic            nmi_edge;
	logic            take;

	level_sel_if sel ();

	// periph_req[k] uses field table below; vector base per group is a
	// parameter-free map (except source 23, set by ALT_CONV_VECTOR) chosen to follow the default order
	function automatic int periph_field(input int k);
		case (k)
			0:  periph_field = 8;   // dma channel 0
			1:  periph_field = 9;   // dma channel 1
			2,3,4,5: periph_field = 12;
			6:  periph_field = 13;
			7,8: periph_field = 14;
			9,10: periph_field = 15;
			11,12: periph_field = 16;
			13,14: periph_field = 17;
			15,16,17,18: periph_field = 22;
			19,20,21,22: periph_field = 23;
			23: periph_field = 24;  // converter
			24: periph_field = 26;
			25: periph_field = 27;
			26,27: periph_field = 28;
			default: periph_field = 28;
		endcase
	endfunction : periph_field

	function automatic logic [7:0] periph_vector(input int k);
		logic [7:0] v [arb_pkg::NUM_PERIPH];
		v = '{8'h48, 8'h4C, 8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h60,
		      8'h61, 8'h64, 8'h65, 8'h68, 8'h69, 8'h6C, 8'h6D, 8'h80,
		      8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88,
		      8'h90, 8'h94, 8'h98, 8'h99, 8'h00, 8'h00, 8'h00, 8'h00};
		periph_vector = v[k];
	endfunction : periph_vector

	// source order: pins first, then peripherals, matching default order
	generate
		for (genvar p = 0; p < NP; p++) begin : g_pin
			// settled low after settled high; a glitch shorter than the
			// synchroniser agreement window never counts as an edge
			assign pin_fall[p] = (pin_sync_reg[p][2] == pin_sync_reg[p][1])
				&& !pin_sync_reg[p][2] && !pin_low_reg[p];
			// level mode shows the synchronised settled pin level (pin_low_reg), edge mode the latch
			assign pin_flag[p] =
				control_reg[arb_pkg::PIN_BIT[p]] ?
				flags_reg[arb_pkg::PIN_BIT[p]] : pin_low_reg[p];
			assign active[p]  = pin_flag[p];
			assign levels[4*p +: 4] =
				prio_reg[arb_pkg::PIN_FIELD[p]/4]
				[15-4*(arb_pkg::PIN_FIELD[p]%4) -: 4];
			assign vectors[8*p +: 8] = arb_pkg::PIN_VEC[p];
		end
		for (genvar k = 0; k < arb_pkg::NUM_PERIPH; k++) begin : g_per
			assign active[NP+k] = periph_req[k];
			assign levels[4*(NP+k) +: 4] =
				prio_reg[periph_field(k)/4]
				[15-4*(periph_field(k)%4) -: 4];
			if (k == 23) begin : g_conv
				assign vectors[8*(NP+k) +: 8] = ALT_CONV_VECTOR ?
					arb_pkg::VEC_CONV_B : arb_pkg::VEC_CONV_A;
			end else begin : g_std
				assign vectors[8*(NP+k) +: 8] = periph_vector(k);
			end
		end
	endgenerate

	level_picker #(.N(NS)) u_picker (
		.active  (active),
		.levels  (levels),
		.vectors (vectors),
		.nmi_req (nmi_pend_reg),
		.sel     (sel)
	);

	// second and third stages must agree before the level is believed
	assign nmi_edge = (nmi_sync_reg[2] == nmi_sync_reg[1])
		&& (nmi_sync_reg[2] != nmi_level_reg)
		&& (nmi_sync_reg[2] == control_reg[arb_pkg::NMI_EDGE_BIT]);

	assign take = (state_reg == arb_pkg::OFFER) && cpu_ack;

	always_comb begin
		for (int i = 0; i < arb_pkg::NUM_PRIO_REGS; i++) begin
			prio_next[i] = prio_reg[i];
			if (wr && addr == arb_pkg::ADDR_PRIO_A + 4'(i))
				prio_next[i] = wdata;
		end
		control_next = control_reg;
		if (wr && addr == arb_pkg::ADDR_CONTROL)
			control_next = wdata & arb_pkg::CONTROL_WMASK;

		nmi_sync_next  = {nmi_sync_reg[1:0], nonmaskable_pin};
		nmi_level_next = (nmi_sync_reg[2] == nmi_sync_reg[1]) ?
			nmi_sync_reg[2] : nmi_level_reg;
		nmi_pend_next  = nmi_pend_reg;
		if (take && held_nmi_reg)
			nmi_pend_next = 1'b0;
		if (nmi_edge)
			nmi_pend_next = 1'b1;

		read_seen_next = read_seen_reg;
		flags_next     = flags_reg;
		for (int p = 0; p < NP; p++) begin
			pin_sync_next[p] = {pin_sync_reg[p][1:0], ext_request_pin_n[p]};
			pin_low_next[p]  = (pin_sync_reg[p][2] == pin_sync_reg[p][1]) ?
				~pin_sync_reg[p][2] : pin_low_reg[p];
		end
		if (rd && addr == arb_pkg::ADDR_FLAGS)
			read_seen_next = flags_reg & arb_pkg::SENSE_MASK;
		for (int p = 0; p < NP; p++) begin
			if (wr && addr == arb_pkg::ADDR_FLAGS
			    && !wdata[arb_pkg::PIN_BIT[p]]
			    && read_seen_reg[arb_pkg::PIN_BIT[p]]) begin
				flags_next[arb_pkg::PIN_BIT[p]]     = 1'b0;
				read_seen_next[arb_pkg::PIN_BIT[p]] = 1'b0;
			end
			if (take && !held_nmi_reg && held_idx_reg == 6'(p))
				flags_next[arb_pkg::PIN_BIT[p]] = 1'b0;
			// set wins over any clear in the same cycle
			if (pin_fall[p] && control_reg[arb_pkg::PIN_BIT[p]])
				flags_next[arb_pkg::PIN_BIT[p]] = 1'b1;
			if (!control_reg[arb_pkg::PIN_BIT[p]])
				flags_next[arb_pkg::PIN_BIT[p]] = 1'b0;
		end

		rdata_next = 16'h0000;
		if (rd) begin
			if (addr < arb_pkg::ADDR_CONTROL)
				rdata_next = prio_reg[addr[2:0]];
			else if (addr == arb_pkg::ADDR_CONTROL) begin
				rdata_next = control_reg & arb_pkg::CONTROL_WMASK;
				rdata_next[arb_pkg::NMI_LEVEL_BIT] = nmi_level_reg;
			end else if (addr == arb_pkg::ADDR_FLAGS) begin
				for (int p = 0; p < NP; p++)
					rdata_next[arb_pkg::PIN_BIT[p]] = pin_flag[p];
			end
		end

		state_next      = state_reg;
		held_level_next = held_level_reg;
		held_vec_next   = held_vec_reg;
		held_idx_next   = held_idx_reg;
		held_nmi_next   = held_nmi_reg;
		case (state_reg)
			arb_pkg::IDLE: begin
				if (sel.is_nmi || (sel.level != 5'h00
				    && sel.level > {1'b0, cpu_mask_level})) begin
					state_next      = arb_pkg::OFFER;
					held_level_next = sel.is_nmi ? 4'hF : sel.level[3:0];
					held_vec_next   = sel.vector;
					held_idx_next   = sel.index;
					held_nmi_next   = sel.is_nmi;
				end
			end
			arb_pkg::OFFER: begin
				if (cpu_ack)
					state_next = arb_pkg::IDLE;
			end
			default: state_next = arb_pkg::IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < arb_pkg::NUM_PRIO_REGS; i++)
				prio_reg[i] <= arb_pkg::PRIO_RESET;
			control_reg    <= arb_pkg::CONTROL_RESET;
			flags_reg      <= arb_pkg::FLAGS_RESET;
			read_seen_reg  <= 16'h0000;
			rdata          <= 16'h0000;
			nmi_sync_reg   <= 3'h0;
			nmi_level_reg  <= 1'b0;
			nmi_pend_reg   <= 1'b0;
			for (int p = 0; p < NP; p++)
				pin_sync_reg[p] <= 3'h7;
			pin_low_reg    <= '0;
			state_reg      <= arb_pkg::IDLE;
			held_level_reg <= 4'h0;
			held_vec_reg   <= 8'h00;
			held_idx_reg   <= 6'h00;
			held_nmi_reg   <= 1'b0;
		end else begin
			prio_reg       <= prio_next;
			control_reg    <= control_next;
			flags_reg      <= flags_next;
			read_seen_reg  <= read_seen_next;
			rdata          <= rdata_next;
			nmi_sync_reg   <= nmi_sync_next;
			nmi_level_reg  <= nmi_level_next;
			nmi_pend_reg   <= nmi_pend_next;
			pin_sync_reg   <= pin_sync_next;
			pin_low_reg    <= pin_low_next;
			state_reg      <= state_next;
			held_level_reg <= held_level_next;
			held_vec_reg   <= held_vec_next;
			held_idx_reg   <= held_idx_next;
			held_nmi_reg   <= held_nmi_next;
		end
	end

	assign cpu_irq        = (state_reg == arb_pkg::OFFER);
	assign cpu_irq_level  = held_level_reg;
	assign cpu_irq_vector = held_vec_reg;
	assign cpu_irq_nmi    = held_nmi_reg;
endmodule : prioritised_interrupt_controller

// *** dv/pic_asserts.sv ***
// Purpose: port-level checks of the interrupt controller
// Assumes: one clock, rst async active high
// Notes: bound to every controller instance
`timescale 1ns/100ps
module pic_asserts (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [3:0]  addr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic [3:0]  cpu_mask_level,
	input wire logic        cpu_irq,
	input wire logic [3:0]  cpu_irq_level,
	input wire logic [7:0]  cpu_irq_vector,
	input wire logic        cpu_irq_nmi,
	input wire logic        cpu_ack
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_hold;
		cpu_irq && !cpu_ack |=>
			cpu_irq && $stable({cpu_irq_level, cpu_irq_vector});
	endproperty
	a_hold: assert property (p_hold) else $error("offer moved");
	property p_drop; cpu_irq && cpu_ack |=> !cpu_irq; endproperty
	a_drop: assert property (p_drop) else $error("offer kept");
	property p_above;
		cpu_irq && !cpu_irq_nmi |-> cpu_irq_level > cpu_mask_level;
	endproperty
	a_above: assert property (p_above) else $error("not above mask");
	property p_lvl0; cpu_irq |-> cpu_irq_level != 4'h0; endproperty
	a_lvl0: assert property (p_lvl0) else $error("zero level");
	property p_nmi;
		cpu_irq && cpu_irq_nmi |->
			cpu_irq_level == 4'hF && cpu_irq_vector == arb_pkg::VEC_NMI;
	endproperty
	a_nmi: assert property (p_nmi) else $error("bad nmi offer");
	property p_crsv;
		rd && addr == arb_pkg::ADDR_CONTROL |=> (rdata & 16'h7E0C) == 16'h0;
	endproperty
	a_crsv: assert property (p_crsv) else $error("control rsv set");
	property p_frsv;
		rd && addr == arb_pkg::ADDR_FLAGS |=> (rdata & 16'hFF0C) == 16'h0;
	endproperty
	a_frsv: assert property (p_frsv) else $error("flags rsv set");
	property p_unmap; rd && addr > 4'h9 |=> rdata == 16'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	c_nmi: cover property (cpu_irq && cpu_irq_nmi);
	c_ack: cover property (cpu_irq && cpu_ack);
	c_flags: cover property (rd && addr == arb_pkg::ADDR_FLAGS);
endmodule : pic_asserts
bind prioritised_interrupt_controller pic_asserts u_pic_asserts (
	.clk, .rst, .addr, .rd, .rdata, .cpu_mask_level, .cpu_irq,
	.cpu_irq_level, .cpu_irq_vector, .cpu_irq_nmi, .cpu_ack);

// *** dv/cpu_model.sv ***
// Purpose: cpu side that accepts offers and keeps the mask
// Assumes: ack_delay cycles of decode before acceptance
// Notes: mask loads on mask_load at any time; an ack in the same cycle overrides it
`timescale 1ns/100ps
module cpu_model (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       cpu_irq,
	input wire logic [3:0] cpu_irq_level,
	input wire logic       cpu_irq_nmi,
	input wire logic [3:0] ack_delay,
	input wire logic       mask_load,
	input wire logic [3:0] mask_value,
	output logic     [3:0] cpu_mask_level,
	output logic           cpu_ack
);
	logic [3:0] wait_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_mask_level <= 4'h0;
			cpu_ack <= 1'b0;
			wait_reg <= 4'h0;
		end else begin
			cpu_ack <= 1'b0;
			if (mask_load)
				cpu_mask_level <= mask_value;
			// mask follows only once the ack has been seen
			if (cpu_ack)
				cpu_mask_level <= cpu_irq_nmi ? 4'hF : cpu_irq_level;
			if (cpu_irq && !cpu_ack && wait_reg == ack_delay) begin
				cpu_ack <= 1'b1;
				wait_reg <= 4'h0;
			end else if (cpu_irq && !cpu_ack)
				wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : cpu_model

// *** dv/prioritised_interrupt_controller_tb.sv ***
// Purpose: self-checking bench for the interrupt controller
// Assumes: pins settle within 6 clocks
// Notes: mid-run reset discards a pending edge flag
`timescale 1ns/100ps
module prioritised_interrupt_controller_tb;
	logic        clk, rst, wr, rd, nmi_pin, ack, irq, inmi, mload;
	logic [3:0]  addr, mask, ilvl, mval, adly;
	logic [15:0] wdata, rdata;
	logic [5:0]  pin_n;
	logic [31:0] preq;
	logic [7:0]  ivec;
	int          num_errors, cmp_count, cyc;

	prioritised_interrupt_controller u_prioritised_interrupt_controller (
		.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
		.nonmaskable_pin(nmi_pin), .ext_request_pin_n(pin_n),
		.periph_req(preq), .cpu_mask_level(mask), .cpu_irq(irq),
		.cpu_irq_level(ilvl), .cpu_irq_vector(ivec),
		.cpu_irq_nmi(inmi), .cpu_ack(ack));
	cpu_model u_cpu_model (.clk, .rst, .cpu_irq(irq),
		.cpu_irq_level(ilvl), .cpu_irq_nmi(inmi), .ack_delay(adly),
		.mask_load(mload), .mask_value(mval), .cpu_mask_level(mask),
		.cpu_ack(ack));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rchk
	task automatic setmask(input logic [3:0] v);
		@(posedge clk);
		mload <= 1'b1;
		mval <= v;
		@(posedge clk);
		mload <= 1'b0;
	endtask : setmask
	task automatic offer(input logic n, input logic [3:0] l,
		input logic [7:0] v);
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
			@(negedge clk);
		chk({2'b0, irq, inmi, ilvl, ivec}, {2'b01, n, l, v});
		for (int i = 0; i < 40 && irq !== 1'b0; i++)
			@(negedge clk);
		tick(3);
	endtask : offer
	task automatic no_offer;
		tick(12);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
	endtask : no_offer
	task automatic pulse;
		pin_n[0] <= 1'b0;
		tick(6);
		pin_n[0] <= 1'b1;
		tick(6);
	endtask : pulse

	task automatic t_regs;
		for (int i = 0; i < 11; i++)
			rchk(4'(i), 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wreg(4'(i), 16'hA5C3 ^ 16'(i));
			rchk(4'(i), 16'hA5C3 ^ 16'(i));
			wreg(4'(i), 16'h0000);
		end
		wreg(4'h8, 16'h81F3);
		rchk(4'h8, 16'h01F3);
		wreg(4'h8, 16'h0000);
		nmi_pin <= 1'b1;
		tick(6);
		rchk(4'h8, 16'h8000);
	endtask : t_regs
	task automatic t_level;
		wreg(4'h0, 16'h3700);
		pin_n <= 6'h3C;
		offer(1'b0, 4'h7, 8'h41);
		rchk(4'h9, 16'h00C0);
		no_offer();
		pin_n <= 6'h3F;
		tick(6);
		rchk(4'h9, 16'h0000);
		wreg(4'h0, 16'h4400);
		setmask(4'h0);
		pin_n <= 6'h3C;
		offer(1'b0, 4'h4, 8'h40);
		no_offer();
		pin_n <= 6'h3F;
	endtask : t_level
	task automatic t_periph;
		adly <= 4'h5;
		wreg(4'h6, 16'h2000);
		setmask(4'h0);
		preq[23] <= 1'b1;
		offer(1'b0, 4'h2, 8'h88);
		preq <= 32'h0;
		wreg(4'h7, 16'h5000);
		setmask(4'h0);
		preq <= 32'h0C00_0000;
		offer(1'b0, 4'h5, 8'h98);
		no_offer();
		preq <= 32'h0;
	endtask : t_periph
	task automatic t_nmi;
		setmask(4'hF);
		nmi_pin <= 1'b0;
		offer(1'b1, 4'hF, arb_pkg::VEC_NMI);
		rchk(4'h8, 16'h0000);
		// rising select: mask stays at 15, the request must still go out
		wreg(4'h8, 16'h0100);
		nmi_pin <= 1'b1;
		offer(1'b1, 4'hF, arb_pkg::VEC_NMI);
		rchk(4'h8, 16'h8100);
	endtask : t_nmi
	task automatic t_edge;
		adly <= 4'h0;
		wreg(4'h8, 16'h0080);
		pulse();
		// a zero write before any read must not clear
		wreg(4'h9, 16'h0000);
		rchk(4'h9, 16'h0080);
		wreg(4'h9, 16'h0000);
		rchk(4'h9, 16'h0000);
		pulse();
		rchk(4'h9, 16'h0080);
		setmask(4'h0);
		offer(1'b0, 4'h4, 8'h40);
		rchk(4'h9, 16'h0000);
		wreg(4'h8, 16'h0080);
		setmask(4'hF);
		pulse();
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(4);
		// edge mode again so the read shows the latch, not the pin
		wreg(4'h8, 16'h0080);
		rchk(4'h9, 16'h0000);
	endtask : t_edge

	initial begin
		{wr, rd, nmi_pin, mload, addr, wdata, mval, adly, preq} = '0;
		pin_n = 6'h3F;
		rst = 1'b1;
		tick(8);
		rst <= 1'b0;
		tick(4);
		t_regs();
		t_level();
		t_periph();
		t_nmi();
		t_edge();
		wrap_up();
	end
endmodule : prioritised_interrupt_controller_tb
